// ---- hdl/gim_pkg.sv ----
// Package of offsets, fields and reset values for the pin interrupt and indicator block
package gim_pkg;
  localparam int unsigned NUM_PINS      = 12;
  localparam int unsigned NUM_IND       = 8;
  // Register byte addresses
  localparam logic [11:0] ADDR_IND_CFG  = 12'h1BC;
  localparam logic [11:0] ADDR_PIN_IRQ  = 12'h1E8;
  localparam logic [11:0] ADDR_SYS_STS  = 12'h1F0;
  localparam logic [11:0] ADDR_SYS_EN   = 12'h1F4;
  localparam logic [11:0] ADDR_EVT_STS  = 12'h1F8;
  localparam logic [11:0] ADDR_EVT_MSK  = 12'h1FC;
  // Field positions
  localparam int unsigned STS_LSB       = 0;
  localparam int unsigned EN_LSB        = 16;
  localparam int unsigned SYS_GPIO_BIT  = 12;
  localparam int unsigned FUN_LSB       = 8;
  localparam int unsigned IND_EN_LSB    = 0;
  // Reset values
  localparam logic [11:0] PIN_STS_RST   = 12'h000;
  localparam logic [11:0] PIN_EN_RST    = 12'h000;
  localparam logic        SYS_EN_RST    = 1'b0;
  localparam logic [1:0]  EVT_RST       = 2'h0;
  // Minimum active time of a pin interrupt level, and cycles at 125 MHz
  localparam int unsigned PIN_MIN_NS    = 40;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned PIN_MIN_CYC   = (PIN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Indicator functions
  typedef enum logic [1:0] {
    GIM_FUN_LINK   = 2'h0,
    GIM_FUN_SPEED  = 2'h1,
    GIM_FUN_ACT    = 2'h2,
    GIM_FUN_DUPLEX = 2'h3
  } gim_fun_e;
endpackage : gim_pkg

// ---- hdl/gim_ind_mux.sv ----
// Indicator selection per low pin: pass-through GPIO or indicator drive
`timescale 1ns/1ps
`default_nettype none
module gim_ind_mux (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] ind_en_i,
  input  wire logic [1:0] ind_fun_i,
  input  wire logic [3:0] link_st_i,
  input  wire logic [7:0] gpio_out_i,
  input  wire logic [7:0] gpio_oe_i,
  output logic      [7:0] pin_out_o,
  output logic      [7:0] pin_oe_o
);
  // One registered output stage per pin
  for (genvar i = 0; i < 8; i++) begin : g_pin
    logic src;
    // Function code picks the status line shown on an indicator
    always_comb begin
      case (gim_pkg::gim_fun_e'(ind_fun_i))
        gim_pkg::GIM_FUN_LINK:   src = link_st_i[0];
        gim_pkg::GIM_FUN_SPEED:  src = link_st_i[1];
        gim_pkg::GIM_FUN_ACT:    src = link_st_i[2];
        gim_pkg::GIM_FUN_DUPLEX: src = link_st_i[3];
        default:                 src = 1'b0;
      endcase
    end
    // Indicator pins always drive; function is only valid when enabled
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        pin_out_o[i] <= 1'b0;
        pin_oe_o[i]  <= 1'b0;
      end else if (ind_en_i[i]) begin // see [R9] see [R10] see [R14]
        pin_out_o[i] <= src;
        pin_oe_o[i]  <= 1'b1;
      end else begin
        pin_out_o[i] <= gpio_out_i[i];
        pin_oe_o[i]  <= gpio_oe_i[i];
      end
    end
  end
endmodule : gim_ind_mux
`default_nettype wire

// ---- hdl/gim_top.sv ----
// Pin interrupt flags, system interrupt combine and indicator configuration
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [R1] Writing one to a pin status flag clears it; zero leaves it.
// [R2] Enabled pin flags OR into bit 12 of system interrupt status.
// [R3] A pin enable bit adds or removes that pin from the OR.
// [R4] Flags capture their source regardless of the enable bits.
// [R5] Host interrupt needs the combined bit and system enable bit 12.
// [R6] Pin enables sit at bits 27:16, read/write, reset zero.
// [R7] Pin flags sit at bits 11:0, reset zero, set by pin conditions.
// [R8] Outside source holds an interrupt level longer than 40 ns.
// [R9] Indicator enable bits 7:0 pick GPIO (0) or indicator (1).
// [R10] Function field 9:8 applies only to pins with indicator enabled.
// [R11] Indicator fields reset from straps sampled at reset release.
// [R12] Loader may replace the latched strap values after reset.
// [R13] Reserved bits read zero and ignore writes.
// [R14] Function codes pick link, speed, activity or duplex.
module gim_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [11:0] pin_irq_src_i,
  input  wire logic [1:0]  indicator_function_strap_i,
  input  wire logic [7:0]  indicator_enable_strap_i,
  input  wire logic        loader_wr_i,
  input  wire logic [1:0]  loader_function_i,
  input  wire logic [7:0]  loader_enable_i,
  input  wire logic [3:0]  link_st_i,
  input  wire logic [7:0]  gpio_out_i,
  input  wire logic [7:0]  gpio_oe_i,
  output logic      [7:0]  pin_out_o,
  output logic      [7:0]  pin_oe_o,
  output logic             host_irq_o,
  output logic             irq_o
);
  logic [11:0] pin_sts_q;
  logic [11:0] pin_en_q;
  logic [1:0]  ind_fun_q;
  logic [7:0]  ind_en_q;
  logic        sys_en_q;
  logic        gpio_comb;
  logic        rst_seen_q;
  logic [1:0]  evt_sts_q;
  logic [1:0]  evt_msk_q;
  logic        gpio_comb_q;
  logic [2:0]  pin_cnt_q [12];
  logic [11:0] pin_hit;
  logic        req;
  logic        wr;
  logic        wr_pin;
  logic        wr_cfg;
  logic        wr_sys;
  logic        wr_evt_sts;
  logic        wr_evt_msk;
  logic [31:0] rd_d;

  // New request only when ack is low, so each access is answered once
  assign req        = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr         = req && wb_we_i;
  assign wr_pin     = wr && (wb_adr_i == gim_pkg::ADDR_PIN_IRQ);
  assign wr_cfg     = wr && (wb_adr_i == gim_pkg::ADDR_IND_CFG);
  assign wr_sys     = wr && (wb_adr_i == gim_pkg::ADDR_SYS_EN);
  assign wr_evt_sts = wr && (wb_adr_i == gim_pkg::ADDR_EVT_STS);
  assign wr_evt_msk = wr && (wb_adr_i == gim_pkg::ADDR_EVT_MSK);

  // Level filter: a pin must stay active for the minimum time before it counts
  for (genvar i = 0; i < 12; i++) begin : g_filt
    always_ff @(posedge clk_i) begin
      if (rst_i || !pin_irq_src_i[i]) begin
        pin_cnt_q[i] <= 3'h0;
      end else if (pin_cnt_q[i] != 3'(gim_pkg::PIN_MIN_CYC)) begin // see [R8]
        pin_cnt_q[i] <= pin_cnt_q[i] + 3'h1;
      end
    end
    assign pin_hit[i] = pin_irq_src_i[i] && (pin_cnt_q[i] == 3'(gim_pkg::PIN_MIN_CYC));
  end

  // Pin flags: set wins over a simultaneous write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_sts_q <= gim_pkg::PIN_STS_RST; // see [R7]
    end else begin
      pin_sts_q <= (pin_sts_q & ~({12{wr_pin && wb_sel_i[0]}} & {4'h0, wb_dat_i[7:0]})
                             & ~({12{wr_pin && wb_sel_i[1]}} & {wb_dat_i[11:8], 8'h00}))
                 | pin_hit; // see [R1] see [R4] see [R7]
    end
  end

  // Pin enables at bits 27:16
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_en_q <= gim_pkg::PIN_EN_RST; // see [R6]
    end else if (wr_pin) begin
      if (wb_sel_i[2]) pin_en_q[7:0]  <= wb_dat_i[23:16]; // see [R6]
      if (wb_sel_i[3]) pin_en_q[11:8] <= wb_dat_i[27:24]; // see [R13]
    end
  end

  // Strap capture in the first cycle after reset release, loader may override
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_seen_q <= 1'b0;
      ind_fun_q  <= 2'h0;
      ind_en_q   <= 8'h00;
    end else if (!rst_seen_q) begin
      rst_seen_q <= 1'b1;
      ind_fun_q  <= indicator_function_strap_i; // see [R11]
      ind_en_q   <= indicator_enable_strap_i;
    end else if (loader_wr_i) begin
      ind_fun_q  <= loader_function_i; // see [R12]
      ind_en_q   <= loader_enable_i;
    end else if (wr_cfg) begin
      if (wb_sel_i[0]) ind_en_q  <= wb_dat_i[7:0]; // see [R9]
      if (wb_sel_i[1]) ind_fun_q <= wb_dat_i[9:8]; // see [R10] see [R13]
    end
  end

  // System-level enable for the GPIO source
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_en_q <= gim_pkg::SYS_EN_RST;
    end else if (wr_sys && wb_sel_i[1]) begin
      sys_en_q <= wb_dat_i[gim_pkg::SYS_GPIO_BIT]; // see [R5]
    end
  end

  // Combined source and host interrupt pin
  assign gpio_comb = |(pin_sts_q & pin_en_q); // see [R2] see [R3]
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_irq_o  <= 1'b0;
      gpio_comb_q <= 1'b0;
    end else begin
      host_irq_o  <= gpio_comb && sys_en_q; // see [R5]
      gpio_comb_q <= gpio_comb;
    end
  end

  // Block events: bit0 combined source rose, bit1 loader overwrote straps
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_sts_q <= gim_pkg::EVT_RST;
      evt_msk_q <= gim_pkg::EVT_RST;
      irq_o     <= 1'b0;
    end else begin
      evt_sts_q <= (evt_sts_q & ~({2{wr_evt_sts && wb_sel_i[0]}} & wb_dat_i[1:0]))
                 | {loader_wr_i && rst_seen_q, gpio_comb && !gpio_comb_q};
      if (wr_evt_msk && wb_sel_i[0]) evt_msk_q <= wb_dat_i[1:0];
      irq_o     <= |(evt_sts_q & ~evt_msk_q); // A set mask bit blocks its event
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_d = 32'h0000_0000;
    case (wb_adr_i)
      gim_pkg::ADDR_PIN_IRQ: rd_d = {4'h0, pin_en_q, 4'h0, pin_sts_q}; // see [R13]
      gim_pkg::ADDR_IND_CFG: rd_d = {22'h0, ind_fun_q, ind_en_q};
      gim_pkg::ADDR_SYS_STS: rd_d = {19'h0, gpio_comb, 12'h000}; // see [R2]
      gim_pkg::ADDR_SYS_EN:  rd_d = {19'h0, sys_en_q, 12'h000};
      gim_pkg::ADDR_EVT_STS: rd_d = {30'h0, evt_sts_q};
      gim_pkg::ADDR_EVT_MSK: rd_d = {30'h0, evt_msk_q};
      default:               rd_d = 32'h0000_0000;
    endcase
  end

  // One-cycle answer, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_d : 32'h0000_0000;
    end
  end

  gim_ind_mux u_mux (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ind_en_i   (ind_en_q),
    .ind_fun_i  (ind_fun_q),
    .link_st_i  (link_st_i),
    .gpio_out_i (gpio_out_i),
    .gpio_oe_i  (gpio_oe_i),
    .pin_out_o  (pin_out_o),
    .pin_oe_o   (pin_oe_o)
  );
endmodule : gim_top
`default_nettype wire

// ---- tb/gim_top_props.sv ----
// Checker of bus timing, reset and reserved bits of the pin interrupt block
`timescale 1ns/1ps
`default_nettype none
module gim_top_props (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        host_irq_o,
  input wire logic        irq_o,
  input wire logic [7:0]  pin_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("data outside ack");
  property p_sts_rsvd; wb_ack_o && $past(!wb_we_i && wb_adr_i == gim_pkg::ADDR_PIN_IRQ)
    |-> wb_dat_o[31:28] == 4'h0 && wb_dat_o[15:12] == 4'h0; endproperty
  a_sts_rsvd: assert property (p_sts_rsvd) else $error("status spare bits set");
  property p_cfg_rsvd; wb_ack_o && $past(!wb_we_i && wb_adr_i == gim_pkg::ADDR_IND_CFG)
    |-> wb_dat_o[31:10] == 22'h0; endproperty
  a_cfg_rsvd: assert property (p_cfg_rsvd) else $error("config spare bits set");
  property p_unmap; wb_ack_o && $past(wb_adr_i == 12'h000) |-> wb_dat_o == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  // Outputs stay quiet on the first edge after every reset release
  property p_rst_out; $fell(rst_i) |-> !wb_ack_o && !host_irq_o && !irq_o && pin_oe_o == 8'h00;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("output busy after reset");
  // Host interrupt only drops one or two cycles after a bus ack
  property p_irq_fall; $fell(host_irq_o) |-> $past(wb_ack_o) || $past(wb_ack_o, 2); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
endmodule : gim_top_props
bind gim_top gim_top_props u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_o, .wb_ack_o, .host_irq_o, .irq_o, .pin_oe_o);
`default_nettype wire

// ---- tb/gim_pin_model.sv ----
// Model of the external sources that drive the pin interrupt levels
`timescale 1ns/1ps
`default_nettype none
module gim_pin_model (
  input  wire logic        clk_i,
  input  wire logic [11:0] fire_i,
  input  wire logic [3:0]  len_i,
  output logic      [11:0] src_o
);
  logic [3:0] cnt_q [12] = '{default: 4'h0};
  // A fired pin holds its level len_i cycles; 6 or more honours the minimum width
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 12; i++) begin
      if (fire_i[i]) cnt_q[i] <= len_i;
      else if (cnt_q[i] != 4'h0) cnt_q[i] <= cnt_q[i] - 4'h1;
    end
  end
  // Registered level, so the pin never moves on the sampling edge
  always_comb begin
    for (int i = 0; i < 12; i++) src_o[i] = (cnt_q[i] != 4'h0);
  end
endmodule : gim_pin_model
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench of the pin interrupt and indicator block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %0t: got %h exp %h", $time, g, e); end end
module testbench;
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0, loader_wr_i = 1'b0, wb_ack_o, host_irq_o, irq_o;
  logic [11:0] wb_adr_i = 12'h000, fire = 12'h000, pin_irq_src_i;
  logic [3:0]  wb_sel_i = 4'h0, len = 4'h0, link_st_i = 4'h0;
  logic [1:0]  indicator_function_strap_i, loader_function_i = 2'h0;
  logic [7:0]  indicator_enable_strap_i, loader_enable_i = 8'h00, gpio_out_i = 8'h00;
  logic [7:0]  gpio_oe_i = 8'h00, pin_out_o, pin_oe_o;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [15:0] seed = 16'h395E;
  int          fail_count = 0, checked = 0, cycles = 0;
  gim_top DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .pin_irq_src_i, .indicator_function_strap_i, .indicator_enable_strap_i,
    .loader_wr_i, .loader_function_i, .loader_enable_i, .link_st_i, .gpio_out_i, .gpio_oe_i,
    .pin_out_o, .pin_oe_o, .host_irq_o, .irq_o);
  gim_pin_model u_pins (.clk_i, .fire_i(fire), .len_i(len), .src_o(pin_irq_src_i));
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr
  function automatic logic [31:0] cfg_exp(input logic [1:0] f, input logic [7:0] e);
    return {22'h0, f, e};
  endfunction : cfg_exp
  function automatic logic [31:0] pin_exp(input logic [11:0] e, input logic [11:0] s);
    return {4'h0, e, 4'h0, s};
  endfunction : pin_exp
  task automatic finish_test;
    $display("Checks %0d, errors %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  // One classic cycle; waits on ack, released at the ack edge or after 16 cycles without one
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
    {wb_adr_i, wb_dat_i, wb_sel_i} <= {a, d, s};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    if (n == 16) fail_count++;
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : wb
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hF);
    `CHK(rd, e)
  endtask : rchk
  task automatic pulse(input logic [11:0] m, input logic [3:0] l);
    @(posedge clk_i);
    {fire, len} <= {m, l};
    @(posedge clk_i);
    fire <= 12'h000;
    repeat (12) @(posedge clk_i);
  endtask : pulse
  // Hang guard well above the roughly 140 cycles of the run
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 5000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    {indicator_function_strap_i, indicator_enable_strap_i} = seed[9:0];
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int r = 0; r < 2; r++) begin
      rchk(gim_pkg::ADDR_PIN_IRQ, 32'h0);
      rchk(gim_pkg::ADDR_IND_CFG, cfg_exp(seed[9:8], seed[7:0]));
      if (r == 0) begin
        seed = lfsr(seed);
        wb(1'b1, gim_pkg::ADDR_PIN_IRQ, {4'hF, seed[11:0], 16'hFFFF}, 4'hC);
        rchk(gim_pkg::ADDR_PIN_IRQ, pin_exp(seed[11:0], 12'h0));
        wb(1'b1, gim_pkg::ADDR_PIN_IRQ, 32'h0, 4'hC);
        pulse(12'h008, 4'h8);
        pulse(12'h800, 4'h2);
        rchk(gim_pkg::ADDR_PIN_IRQ, pin_exp(12'h0, 12'h008));
        wb(1'b1, gim_pkg::ADDR_SYS_EN, 32'h1000, 4'h2);
        wb(1'b1, gim_pkg::ADDR_PIN_IRQ, 32'h0001_0000, 4'hC);
        rchk(gim_pkg::ADDR_SYS_STS, 32'h0);
        `CHK(host_irq_o, 1'b0)
        wb(1'b1, gim_pkg::ADDR_PIN_IRQ, 32'h0008_0000, 4'hC);
        rchk(gim_pkg::ADDR_SYS_STS, 32'h1000);
        `CHK({host_irq_o, irq_o}, 2'b11)
        wb(1'b1, gim_pkg::ADDR_SYS_EN, 32'h0, 4'h2);
        wb(1'b1, gim_pkg::ADDR_EVT_MSK, 32'h1, 4'h1);
        rchk(gim_pkg::ADDR_SYS_STS, 32'h1000);
        `CHK({host_irq_o, irq_o}, 2'b00)
        wb(1'b1, gim_pkg::ADDR_EVT_STS, 32'h3, 4'h1);
        wb(1'b1, gim_pkg::ADDR_EVT_MSK, 32'h0, 4'h1);
        rchk(gim_pkg::ADDR_EVT_STS, 32'h0);
        wb(1'b1, gim_pkg::ADDR_PIN_IRQ, 32'h0, 4'h3);
        rchk(gim_pkg::ADDR_PIN_IRQ, pin_exp(12'h008, 12'h008));
        wb(1'b1, gim_pkg::ADDR_PIN_IRQ, 32'h8, 4'h1);
        rchk(gim_pkg::ADDR_PIN_IRQ, pin_exp(12'h008, 12'h0));
        @(posedge clk_i);
        {loader_wr_i, loader_function_i, loader_enable_i} <= {1'b1, seed[13:4]};
        @(posedge clk_i);
        loader_wr_i <= 1'b0;
        rchk(gim_pkg::ADDR_IND_CFG, cfg_exp(seed[13:12], seed[11:4]));
        for (int f = 0; f < 4; f++) begin
          seed = lfsr(seed);
          {gpio_out_i, gpio_oe_i} <= {seed[7:0], seed[15:8]};
          link_st_i <= seed[3:0];
          wb(1'b1, gim_pkg::ADDR_IND_CFG, cfg_exp(f[1:0], 8'h0F), 4'h3);
          rchk(gim_pkg::ADDR_IND_CFG, cfg_exp(f[1:0], 8'h0F));
          `CHK({pin_out_o[7:4], pin_oe_o[7:4]}, {seed[7:4], seed[15:12]})
          `CHK({pin_out_o[3:0], pin_oe_o[3:0]}, {{4{seed[f]}}, 4'hF})
        end
        wb(1'b1, 12'h000, 32'hFFFF_FFFF, 4'hF);
        rchk(12'h000, 32'h0);
        seed = 16'h395E;
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
      end
    end
    finish_test();
  end
endmodule : testbench
`default_nettype wire
